// >>> hw/cys_top.sv
// Purpose: eight calendar switch units of four channels each, behind an apb slave
// Assumes: calendar is kept running elsewhere from backup; inputs synchronous to pclk
// Notes: zero wait state slave; contacts move only on evaluation strobes, or open when the calendar check fails
`timescale 1ns/10ps
module cys_top
	import cys_pkg::*;
#(
	parameter int ADDR_W = CYS_AW
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// calendar and supply
	input wire logic [4:0] cal_day,
	input wire logic [3:0] cal_month,
	input wire logic [6:0] cal_year,
	input wire logic main_power_ok,
	// switch outputs
	output logic [CYS_UNITS-1:0] calendar_switch_contact,
	output logic [CYS_UNITS-1:0] param_visible
);
	cys_date_t on_r [CYS_TOTAL];
	cys_date_t off_r [CYS_TOTAL];
	logic [CYS_TOTAL-1:0] pair_r;
	logic [7:0] ctrl_r;
	logic [4:0] sel_r;
	logic [CYS_TOTAL-1:0] act_r;
	logic [CYS_UNITS-1:0] contact_r;
	logic [CYS_UNITS-1:0] contact_nxt;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic touch_r;
	logic [CYS_TOTAL-1:0] act_raw;
	logic [CYS_TOTAL-1:0] act_m;

	cys_cal_if cal ();

	// address decode
	wire [11:0] addr12 = 12'(paddr);
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_chan = addr12 <= CYS_OFF_CHAN_LAST && addr12[1:0] == 2'h0;
	wire hit_ctrl = addr12 == CYS_OFF_CTRL;
	wire hit_sel = addr12 == CYS_OFF_SEL;
	wire hit_status = addr12 == CYS_OFF_STATUS;
	wire [4:0] a_ch = addr12[7:3];
	wire a_off = addr12[2];

	// write data as a date
	cys_date_t wr_date;
	assign wr_date = '{year_en: pwdata[CYS_YEAR_EN_BIT], mon_en: pwdata[CYS_MON_EN_BIT],
		day_en: pwdata[CYS_DAY_EN_BIT], year: pwdata[CYS_YEAR_LSB +: 7], month: pwdata[CYS_MON_LSB +: 4],
		day: pwdata[CYS_DAY_LSB +: 5]};
	wire wr_date_ok = cys_date_ok(wr_date);

	// refused writes leave storage untouched and answer with pslverr
	wire bad = pwrite ? !((hit_chan && wr_date_ok) || hit_ctrl || hit_sel)
		: !(hit_chan || hit_ctrl || hit_sel || hit_status);
	wire wr_ok = access && pwrite && !pslverr_r;
	wire wr_chan = wr_ok && hit_chan;
	wire wr_ctrl = wr_ok && hit_ctrl;
	wire wr_sel = wr_ok && hit_sel;

	// read data
	wire [2:0] sel_unit = sel_r[4:2];
	wire [31:0] chan_word = a_off ? cys_pack(off_r[a_ch], 1'b0) : cys_pack(on_r[a_ch], pair_r[a_ch]);
	wire [31:0] status_word = (32'(contact_r) << CYS_ST_ALL_LSB)
		| (32'(contact_r[sel_unit]) << CYS_ST_CONTACT_BIT)
		| (32'(act_r[sel_r]) << CYS_ST_ACTIVE_BIT)
		| (32'(cal.cal_ok) << CYS_ST_CALOK_BIT);
	wire [31:0] rd_word = hit_chan ? chan_word
		: hit_ctrl ? {24'h00_0000, ctrl_r}
		: hit_sel ? {27'h000_0000, sel_r}
		: hit_status ? status_word
		: 32'h0000_0000;

	// apb answer; read data and error are latched in the setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else if (setup)
		begin
			prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
			pslverr_r <= bad;
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = access && pslverr_r;

	// parameter storage, one on and one off date per channel
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < CYS_TOTAL; i++)
			begin
				on_r[i] <= CYS_DATE_RST;
				off_r[i] <= CYS_DATE_RST;
			end
			pair_r <= '0;
		end
		else if (wr_chan)
		begin
			if (a_off)
				off_r[a_ch] <= wr_date;
			else
			begin
				on_r[a_ch] <= wr_date;
				pair_r[a_ch] <= pwdata[CYS_PAIR_BIT];
			end
		end
	end

	// control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= CYS_CTRL_RST;
			sel_r <= CYS_SEL_RST;
			touch_r <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= pwdata[7:0];
			if (wr_sel)
				sel_r <= pwdata[4:0];
			touch_r <= wr_chan;
		end
	end

	assign param_visible = ctrl_r;

	cys_cal_watch u_watch (
		.pclk(pclk),
		.presetn(presetn),
		.cal_day(cal_day),
		.cal_month(cal_month),
		.cal_year(cal_year),
		.main_power_ok(main_power_ok),
		.param_touch(touch_r),
		.cal(cal)
	);

	// per channel evaluation; a paired channel borrows the off date of its upper neighbour
	for (genvar g = 0; g < CYS_TOTAL; g++)
	begin : g_chan
		localparam int C = g % CYS_CHANS;
		wire cont;
		wire supp;
		cys_date_t off_src;
		if (C < CYS_CHANS - 1)
		begin : g_pair
			assign cont = pair_r[g];
			assign off_src = pair_r[g] ? off_r[g + 1] : off_r[g];
		end
		else
		begin : g_last
			// last channel has no neighbour, a pair bit here is ignored
			assign cont = 1'b0;
			assign off_src = off_r[g];
		end
		if (C > 0)
		begin : g_supp
			assign supp = pair_r[g - 1];
		end
		else
		begin : g_nosupp
			assign supp = 1'b0;
		end
		cys_chan_eval u_eval (
			.cal(cal),
			.on_d(on_r[g]),
			.off_d(off_src),
			.cont(cont),
			.active(act_raw[g])
		);
		assign act_m[g] = act_raw[g] && !supp;
	end

	// contact: an off edge in any channel opens, else an on edge closes
	for (genvar u = 0; u < CYS_UNITS; u++)
	begin : g_unit
		wire [CYS_CHANS-1:0] now = act_m[u*CYS_CHANS +: CYS_CHANS];
		wire [CYS_CHANS-1:0] was = act_r[u*CYS_CHANS +: CYS_CHANS];
		wire rise = |(now & ~was);
		wire fall = |(~now & was);
		assign contact_nxt[u] = fall ? 1'b0 : (rise ? 1'b1 : contact_r[u]);
	end

	// trades full level tracking for the first-on/first-off order on overlaps
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act_r <= '0;
			contact_r <= '0;
		end
		else if (!cal.cal_ok)
		begin
			act_r <= '0;
			contact_r <= '0;
		end
		else if (cal.eval)
		begin
			act_r <= act_m;
			contact_r <= contact_nxt;
		end
	end

	assign calendar_switch_contact = contact_r;

endmodule : cys_top

// >>> hw/cys_pkg.sv
// Purpose: shared constants, date type and helpers for the calendar switch block
// Assumes: calendar fields arrive as binary values, year as two digits
// Notes: register map offsets are byte addresses on a 32-bit apb bus
package cys_pkg;

	localparam int CYS_UNITS = 8;
	localparam int CYS_CHANS = 4;
	localparam int CYS_TOTAL = 32;
	localparam int CYS_AW = 12;

	localparam logic [11:0] CYS_OFF_CHAN_LAST = 12'h00fc;
	localparam logic [11:0] CYS_OFF_CTRL = 12'h0100;
	localparam logic [11:0] CYS_OFF_SEL = 12'h0104;
	localparam logic [11:0] CYS_OFF_STATUS = 12'h0108;

	localparam int CYS_DAY_LSB = 0;
	localparam int CYS_MON_LSB = 8;
	localparam int CYS_YEAR_LSB = 16;
	localparam int CYS_DAY_EN_BIT = 24;
	localparam int CYS_MON_EN_BIT = 25;
	localparam int CYS_YEAR_EN_BIT = 26;
	localparam int CYS_PAIR_BIT = 28;
	localparam int CYS_ST_CONTACT_BIT = 0;
	localparam int CYS_ST_ACTIVE_BIT = 1;
	localparam int CYS_ST_CALOK_BIT = 2;
	localparam int CYS_ST_ALL_LSB = 8;

	localparam logic [4:0] CYS_DAY_MIN = 5'h01;
	localparam logic [4:0] CYS_DAY_MAX = 5'h1f;
	localparam logic [3:0] CYS_MON_MIN = 4'h1;
	localparam logic [3:0] CYS_MON_MAX = 4'hc;
	localparam logic [6:0] CYS_YEAR_MAX = 7'h63;
	localparam logic [6:0] CYS_CAL_YEAR_MIN = 7'h01;

	localparam logic [7:0] CYS_CTRL_RST = 8'hff;
	localparam logic [4:0] CYS_SEL_RST = 5'h00;

	typedef struct packed {
		logic year_en;
		logic mon_en;
		logic day_en;
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] day;
	} cys_date_t;

	localparam cys_date_t CYS_DATE_RST = '0;

	// inclusive range; lo above hi wraps around the field
	function automatic logic cys_in_range(input logic [6:0] cur, input logic [6:0] lo, input logic [6:0] hi);
		cys_in_range = (lo <= hi) ? (cur >= lo && cur <= hi) : (cur >= lo || cur <= hi);
	endfunction : cys_in_range

	// ordering key, unpopulated fields drop out of the comparison
	function automatic logic [15:0] cys_key(input cys_date_t m, input logic [6:0] y, input logic [3:0] mo,
		input logic [4:0] d);
		cys_key = {(m.year_en ? y : 7'h00), (m.mon_en ? mo : 4'h0), (m.day_en ? d : 5'h00)};
	endfunction : cys_key

	function automatic logic cys_date_ok(input cys_date_t d);
		cys_date_ok = (!d.day_en || (d.day >= CYS_DAY_MIN && d.day <= CYS_DAY_MAX))
			&& (!d.mon_en || (d.month >= CYS_MON_MIN && d.month <= CYS_MON_MAX))
			&& (!d.year_en || d.year <= CYS_YEAR_MAX);
	endfunction : cys_date_ok

	function automatic logic [31:0] cys_pack(input cys_date_t d, input logic pair);
		cys_pack = {3'h0, pair, 1'b0, d.year_en, d.mon_en, d.day_en, 1'b0, d.year,
			4'h0, d.month, 3'h0, d.day};
	endfunction : cys_pack

endpackage : cys_pkg

// >>> hw/cys_cal_if.sv
// Purpose: carries the checked calendar date and the evaluation strobe
// Assumes: one clock domain
// Notes: driven by the calendar watcher only
`timescale 1ns/10ps
interface cys_cal_if;
	logic [4:0] day;
	logic [3:0] month;
	logic [6:0] year;
	logic cal_ok;
	logic eval;
	modport src (output day, output month, output year, output cal_ok, output eval);
	modport dst (input day, input month, input year, input cal_ok, input eval);
endinterface : cys_cal_if

// >>> hw/cys_cal_watch.sv
// Purpose: registers the calendar, checks its range and raises evaluation strobes
// Assumes: calendar inputs synchronous to pclk
// Notes: eval is one cycle, aligned with the registered date it refers to
`timescale 1ns/10ps
module cys_cal_watch
	import cys_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// calendar and supply
	input wire logic [4:0] cal_day,
	input wire logic [3:0] cal_month,
	input wire logic [6:0] cal_year,
	input wire logic main_power_ok,
	// parameter change pulse
	input wire logic param_touch,
	// to the evaluators
	cys_cal_if.src cal
);
	logic [4:0] day_r;
	logic [3:0] month_r;
	logic [6:0] year_r;
	logic ok_r;
	logic eval_r;

	// year 00 would be 2000, outside the clock's working range
	wire in_valid = cal_day >= CYS_DAY_MIN && cal_day <= CYS_DAY_MAX && cal_month >= CYS_MON_MIN
		&& cal_month <= CYS_MON_MAX && cal_year >= CYS_CAL_YEAR_MIN && cal_year <= CYS_YEAR_MAX;
	wire ok_nxt = main_power_ok && in_valid;
	wire changed = cal_day != day_r || cal_month != month_r || cal_year != year_r;
	wire eval_nxt = changed || param_touch || (ok_nxt && !ok_r);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			day_r <= 5'h00;
			month_r <= 4'h0;
			year_r <= 7'h00;
			ok_r <= 1'b0;
			eval_r <= 1'b0;
		end
		else
		begin
			day_r <= cal_day;
			month_r <= cal_month;
			year_r <= cal_year;
			ok_r <= ok_nxt;
			eval_r <= eval_nxt;
		end
	end

	assign cal.day = day_r;
	assign cal.month = month_r;
	assign cal.year = year_r;
	assign cal.cal_ok = ok_r;
	assign cal.eval = eval_r;
endmodule : cys_cal_watch

// >>> hw/cys_chan_eval.sv
// Purpose: decides whether one channel's interval covers today
// Assumes: the configuring side enters on and off dates with matching fields
// Notes: purely combinational, sampled by the top on the eval strobe
`timescale 1ns/10ps
module cys_chan_eval
	import cys_pkg::*;
(
	// calendar
	cys_cal_if.dst cal,
	// channel setup
	input wire cys_date_t on_d,
	input wire cys_date_t off_d,
	input wire logic cont,
	// result
	output logic active
);
	// a channel with no populated on field switches nothing
	wire used = on_d.day_en || on_d.mon_en || on_d.year_en;

	// each populated field must sit in its own range; off field inclusive
	wire day_hit = !on_d.day_en || cys_in_range({2'h0, cal.day}, {2'h0, on_d.day}, {2'h0, off_d.day});
	wire mon_hit = !on_d.mon_en || cys_in_range({3'h0, cal.month}, {3'h0, on_d.month}, {3'h0, off_d.month});
	wire year_hit = !on_d.year_en || cys_in_range(cal.year, on_d.year, off_d.year);
	wire rec_hit = day_hit && mon_hit && year_hit;

	// continuous: whole dates compared, wrapping across the year end
	wire [15:0] on_k = cys_key(on_d, on_d.year, on_d.month, on_d.day);
	wire [15:0] off_k = cys_key(off_d, off_d.year, off_d.month, off_d.day);
	wire [15:0] cur_on_k = cys_key(on_d, cal.year, cal.month, cal.day);
	wire [15:0] cur_off_k = cys_key(off_d, cal.year, cal.month, cal.day);
	wire cont_hit = (on_k <= off_k) ? (cur_on_k >= on_k && cur_off_k <= off_k)
		: (cur_on_k >= on_k || cur_off_k <= off_k);

	assign active = used && (cont ? cont_hit : rec_hit);
endmodule : cys_chan_eval

// >>> sim/cys_top_checker.sv
// Purpose: port level assertions for the calendar switch top
// Assumes: zero wait apb slave, contacts move only on evaluation strobes or open when the calendar check fails
// Notes: bound into cys_top at the foot of this file
`timescale 1ns/10ps
module cys_top_checker
	import cys_pkg::*;
#(
	parameter int ADDR_W = CYS_AW
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// calendar and supply
	input wire logic [4:0] cal_day,
	input wire logic [3:0] cal_month,
	input wire logic [6:0] cal_year,
	input wire logic main_power_ok,
	// switch outputs
	input wire logic [CYS_UNITS-1:0] calendar_switch_contact,
	input wire logic [CYS_UNITS-1:0] param_visible
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire wr_acc = acc && pwrite;
	wire [7:0] wd = pwdata[7:0];
	wire chan_a = paddr <= CYS_OFF_CHAN_LAST && paddr[1:0] == 2'b00;
	// only enabled fields are range checked
	wire bad_f = (pwdata[24] && pwdata[4:0] == 5'h00) || (pwdata[25] && (pwdata[11:8] == 4'h0 || pwdata[11:8] > 4'hc))
		|| (pwdata[26] && pwdata[22:16] > 7'h63);
	a_power_open: assert property (!main_power_ok ##1 !main_power_ok |=> calendar_switch_contact == '0)
		else $error("contact closed without main power");
	a_rise_powered: assert property ((calendar_switch_contact & ~$past(calendar_switch_contact)) != '0 |->
		$past(main_power_ok)) else $error("contact closed while unpowered");
	// a parameter write also re-evaluates, so any write breaks the quiet spell
	a_contact_quiet: assert property (($stable(cal_day) && $stable(cal_month) && $stable(cal_year) && main_power_ok
		&& !wr_acc) [*5] |=> $stable(calendar_switch_contact)) else $error("contact moved without cause");
	a_status_ro: assert property (wr_acc && paddr == CYS_OFF_STATUS |-> pslverr) else $error("status write taken");
	a_field_range: assert property (wr_acc && chan_a && bad_f |-> pslverr) else $error("bad field taken");
	a_vis_follow: assert property (wr_acc && paddr == CYS_OFF_CTRL |-> !pslverr ##1 param_visible == $past(wd))
		else $error("visibility not updated");
	a_status_all: assert property (acc && !pwrite && paddr == CYS_OFF_STATUS |->
		prdata[15:8] == $past(calendar_switch_contact)) else $error("status contacts differ");
	a_unmapped_err: assert property (acc && paddr > CYS_OFF_STATUS |-> pslverr) else $error("unmapped access taken");
endmodule : cys_top_checker

bind cys_top cys_top_checker #(.ADDR_W(ADDR_W)) cys_top_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cal_day(cal_day), .cal_month(cal_month), .cal_year(cal_year), .main_power_ok(main_power_ok),
	.calendar_switch_contact(calendar_switch_contact), .param_visible(param_visible));

// >>> sim/testbench.sv
// Purpose: self-checking bench for the calendar switch top
// Assumes: zero wait apb slave, contacts settle within four edges
// Notes: apb results are queued by the driver and matched at each access phase
`timescale 1ns/10ps
module testbench
	import cys_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, main_power_ok, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0] cal_day;
	logic [3:0] cal_month;
	logic [6:0] cal_year;
	logic [7:0] contact, vis, r;
	logic [32:0] q[$];
	logic [32:0] nt;
	int fail_count, n_tests, seed, i;
	// {day, month, year, contacts} walk over recurring and year-end continuous ranges
	logic [31:0] tb[8] = '{32'h1f0a_0a01, 32'h010b_0a00, 32'h1e0c_0a00, 32'h1f0c_0a08, 32'h0101_0b08,
		32'h0201_0b0a, 32'h0301_0b02, 32'h1a04_0b01};
	cys_top #(.ADDR_W(12)) cys_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cal_day(cal_day), .cal_month(cal_month), .cal_year(cal_year), .main_power_ok(main_power_ok),
		.calendar_switch_contact(contact), .param_visible(vis));
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	function automatic logic [31:0] w(input logic [2:0] en, input logic pr, input logic [4:0] d, input logic [3:0] m,
		input logic [6:0] y);
		w = {3'h0, pr, 1'b0, en, 1'b0, y, 4'h0, m, 3'h0, d};
	endfunction : w
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
		input logic er);
		int k;
		q.push_back({e, er});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1)
		begin
			fail_count++;
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic er);
		apb(1'b1, a, d, '0, er);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
		apb(1'b0, a, '0, e, er);
	endtask : rd
	// new date, then status of unit u with all contacts c
	task automatic day(input logic [4:0] d, input logic [3:0] m, input logic [6:0] y, input logic [7:0] c, input int u);
		cal_day <= d;
		cal_month <= m;
		cal_year <= y;
		repeat (4) @(posedge pclk);
		rd(CYS_OFF_STATUS, {16'h0000, c, 5'h00, 1'b1, c[u], c[u]}, 1'b0);
	endtask : day
	// sampled mid-cycle so registered outputs have settled
	always @(negedge pclk)
		if (presetn && psel && penable && pready)
		begin
			nt = q.pop_front();
			check("prdata", nt[32:1], prdata);
			check("pslverr", {31'h0, nt[0]}, {31'h0, pslverr});
		end
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{cal_day, cal_month, cal_year, main_power_ok} = {5'h0f, 4'h6, 7'h0a, 1'b1};
		fail_count = 0;
		n_tests = 0;
		seed = 32'h0000_958f;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CYS_OFF_CTRL, 32'h0000_00ff, 1'b0);
		rd(CYS_OFF_SEL, '0, 1'b0);
		rd(CYS_OFF_STATUS, 32'h0000_0004, 1'b0);
		r = 8'($random(seed));
		wr(CYS_OFF_CTRL, {24'h00_0000, r}, 1'b0);
		@(negedge pclk);
		check("visible", {24'h00_0000, r}, {24'h00_0000, vis});
		@(posedge pclk);
		rd(12'h10c, '0, 1'b1);
		wr(12'h002, '0, 1'b1);
		wr(CYS_OFF_STATUS, '0, 1'b1);
		wr(12'h008, w(3'b001, 1'b0, 5'h00, 4'h0, 7'h00), 1'b1);
		wr(12'h008, w(3'b010, 1'b0, 5'h00, 4'hd, 7'h00), 1'b1);
		wr(12'h008, w(3'b100, 1'b0, 5'h00, 4'h0, 7'h64), 1'b1);
		rd(12'h008, '0, 1'b0);
		wr(12'h000, w(3'b010, 1'b0, 5'h00, 4'h4, 7'h00), 1'b0);
		wr(12'h004, w(3'b010, 1'b0, 5'h00, 4'ha, 7'h00), 1'b0);
		wr(12'h020, w(3'b001, 1'b0, 5'h02, 4'h0, 7'h00), 1'b0);
		wr(12'h024, w(3'b001, 1'b0, 5'h19, 4'h0, 7'h00), 1'b0);
		wr(12'h060, w(3'b011, 1'b1, 5'h1f, 4'hc, 7'h00), 1'b0);
		wr(12'h06c, w(3'b011, 1'b0, 5'h02, 4'h1, 7'h00), 1'b0);
		rd(12'h060, w(3'b011, 1'b1, 5'h1f, 4'hc, 7'h00), 1'b0);
		day(5'h0f, 4'h6, 7'h0a, 8'h03, 0);
		for (i = 0; i < 8; i++)
			day(tb[i][28:24], tb[i][19:16], tb[i][14:8], tb[i][7:0], 0);
		main_power_ok <= 1'b0;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		check("contact", '0, {24'h00_0000, contact});
		@(posedge pclk);
		rd(CYS_OFF_STATUS, '0, 1'b0);
		main_power_ok <= 1'b1;
		day(5'h1a, 4'h4, 7'h0b, 8'h01, 0);
		cal_year <= 7'h00;
		repeat (4) @(posedge pclk);
		rd(CYS_OFF_STATUS, '0, 1'b0);
		day(5'h0a, 4'h4, 7'h63, 8'h03, 0);
		wr(CYS_OFF_SEL, 32'h0000_0004, 1'b0);
		rd(CYS_OFF_STATUS, 32'h0000_0307, 1'b0);
		// unit 2 overlap: may-june and june-july, the first off opens the contact
		wr(12'h040, w(3'b010, 1'b0, 5'h00, 4'h5, 7'h00), 1'b0);
		wr(12'h044, w(3'b010, 1'b0, 5'h00, 4'h6, 7'h00), 1'b0);
		wr(12'h048, w(3'b010, 1'b0, 5'h00, 4'h6, 7'h00), 1'b0);
		wr(12'h04c, w(3'b010, 1'b0, 5'h00, 4'h7, 7'h00), 1'b0);
		day(5'h01, 4'h5, 7'h63, 8'h05, 1);
		day(5'h01, 4'h6, 7'h63, 8'h05, 1);
		day(5'h01, 4'h7, 7'h63, 8'h01, 1);
		complete_run();
	end
endmodule : testbench
